// [src/delay_status_bank.v]
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "delay_status_regs.vh"
// Summary of operation
// - toggle load ack per completed single-update load
// - ready flag only after parameterization
// - echo soft enable request in status
// - running flag while output sequence active
// - report main output pin level
// - report secondary output pin level
// - report digital input level
// - count both edges of main output
// - unassigned status bits and unmapped bytes read zero
// - channel 1 eight indices (32 bytes) higher, optional
// - main output follows input with delays
// - flag invalid slot value in permanent mode
module delay_status_bank #(
	parameter TWO_CHANNELS = 1,
	parameter DELAY_W      = `DELAY_W
) (
	input  wire        clock,
	input  wire        rst,
	input  wire [5:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	input  wire [1:0]  in0_pin,
	output wire [1:0]  pulse_out_main,
	output wire [1:0]  pulse_out_second,
	output wire        irq
);
	localparam NCH = TWO_CHANNELS ? 2 : 1;

	reg  [15:0]        ctrl_r;
	reg  [31:0]        delays_r [0:1];
	reg  [`IRQ_W-1:0]  irq_status_r;
	reg  [`IRQ_W-1:0]  irq_status_nxt;
	reg  [`IRQ_W-1:0]  irq_mask_r;
	reg                ack_r;
	reg  [7:0]         rbyte;

	wire [1:0] main_w;
	wire [1:0] second_w;
	wire [1:0] in_lvl;
	wire [1:0] run_w;
	wire [1:0] ack_w;
	wire [1:0] rdy_w;
	wire [1:0] inval_w;
	wire [7:0] cnt_w;
	wire [1:0] edge_w;
	wire [1:0] load_w;
	// an absent channel must not echo its enable bit
	wire [1:0] soft_en_w = {ctrl_r[8 + `CTL_SOFT_EN] & (NCH > 1), ctrl_r[`CTL_SOFT_EN]};

	wire [3:0] idx = address[5:2];

	// byte image of one channel's status, unassigned bits zero;
	// every source is an argument so the read decode sees each change
	function [7:0] status_byte;
		input [1:0] sel;
		input       inval;
		input       ack;
		input       rdy;
		input       soft_en;
		input       run;
		input       out_a;
		input       out_b;
		input       lvl;
		input [3:0] cnt;
		begin
			status_byte = 8'h00;
			case (sel)
				2'd0: status_byte[`BIT_SLOT_INVALID] = inval;
				2'd1: begin
					status_byte[`BIT_LOAD_ACK] = ack;
					status_byte[`BIT_READY]    = rdy;
					status_byte[`BIT_SOFT_EN]  = soft_en;
				end
				2'd2: begin
					status_byte[`BIT_RUNNING] = run;
					status_byte[`BIT_OUT_A]   = out_a;
					status_byte[`BIT_OUT_B]   = out_b;
					status_byte[`BIT_IN0]     = lvl;
				end
				default: status_byte[3:0] = cnt;
			endcase
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			if (g < NCH) begin : on
				delay_channel #(.DELAY_W(DELAY_W)) u_ch (
					.clock                 (clock),
					.rst                   (rst),
					.in0_pin               (in0_pin[g]),
					.soft_enable_request   (ctrl_r[g*8 + `CTL_SOFT_EN]),
					.slot_perm_mode        (ctrl_r[g*8 + `CTL_SLOT_PERM]),
					.slot_load_request     (ctrl_r[g*8 + `CTL_LOAD_REQ]),
					.param_done            (ctrl_r[g*8 + `CTL_PARAM_DONE]),
					.out_b_req             (ctrl_r[g*8 + `CTL_OUT_B]),
					.on_delay              (delays_r[g][DELAY_W-1:0]),
					.off_delay             (delays_r[g][16+DELAY_W-1:16]),
					.pulse_out_main        (main_w[g]),
					.pulse_out_second      (second_w[g]),
					.in0_level             (in_lvl[g]),
					.sequence_running_flag (run_w[g]),
					.load_ack_toggle       (ack_w[g]),
					.param_ready_flag      (rdy_w[g]),
					.slot_value_invalid    (inval_w[g]),
					.out_edge_count        (cnt_w[g*4+3:g*4]),
					.edge_pulse            (edge_w[g]),
					.load_pulse            (load_w[g])
				);
			end else begin : off
				// absent channel reads all zero
				assign main_w[g]         = 1'b0;
				assign second_w[g]       = 1'b0;
				assign in_lvl[g]         = 1'b0;
				assign run_w[g]          = 1'b0;
				assign ack_w[g]          = 1'b0;
				assign rdy_w[g]          = 1'b0;
				assign inval_w[g]        = 1'b0;
				assign cnt_w[g*4+3:g*4]  = 4'h0;
				assign edge_w[g]         = 1'b0;
				assign load_w[g]         = 1'b0;
			end
		end
	endgenerate

	assign pulse_out_main   = main_w;
	assign pulse_out_second = second_w;
	assign irq              = |(irq_status_r & irq_mask_r);

	// one wait cycle per access; answer registered at the first edge, taken at the second
	assign waitrequest = (read | write) & ~ack_r;

	// read decode, channel 1 is the same layout one stride higher
	always @* begin
		rbyte = 8'h00;
		case (idx)
			`IDX_CH0_ERRORS, `IDX_CH0_CTRL_STS, `IDX_CH0_RUN_PINS, `IDX_CH0_EDGE_CNT:
				rbyte = status_byte(idx[1:0], inval_w[0], ack_w[0], rdy_w[0], soft_en_w[0],
					run_w[0], main_w[0], second_w[0], in_lvl[0], cnt_w[3:0]);
			`IDX_CH1_ERRORS, `IDX_CH1_CTRL_STS, `IDX_CH1_RUN_PINS, `IDX_CH1_EDGE_CNT:
				rbyte = status_byte(idx[1:0], inval_w[1], ack_w[1], rdy_w[1], soft_en_w[1],
					run_w[1], main_w[1], second_w[1], in_lvl[1], cnt_w[7:4]);
			default: rbyte = 8'h00;
		endcase
	end

	// sticky events: set wins over the clear-on-read
	always @* begin
		irq_status_nxt = irq_status_r;
		if (read && !ack_r && idx == `IDX_IRQ_STATUS)
			irq_status_nxt = {`IRQ_W{1'b0}};
		irq_status_nxt = irq_status_nxt | {load_w[1], edge_w[1], load_w[0], edge_w[0]};
	end

	// bus slave
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			ack_r        <= 1'b0;
			readdata     <= 32'h0000_0000;
			ctrl_r       <= 16'h0000;
			delays_r[0]  <= `DELAY_RESET;
			delays_r[1]  <= `DELAY_RESET;
			irq_status_r <= {`IRQ_W{1'b0}};
			irq_mask_r   <= {`IRQ_W{1'b0}};
		end else begin
			ack_r        <= (read | write) & ~ack_r;
			irq_status_r <= irq_status_nxt;
			if (read && !ack_r) begin
				case (idx)
					`IDX_CTRL:       readdata <= {16'h0000, ctrl_r};
					`IDX_DELAYS_CH0: readdata <= delays_r[0];
					`IDX_DELAYS_CH1: readdata <= delays_r[1];
					`IDX_IRQ_STATUS: readdata <= {{(32-`IRQ_W){1'b0}}, irq_status_r};
					`IDX_IRQ_MASK:   readdata <= {{(32-`IRQ_W){1'b0}}, irq_mask_r};
					default:         readdata <= {24'h000000, rbyte};
				endcase
			end
			if (write && !ack_r) begin
				case (idx)
					`IDX_CTRL: begin
						if (byteenable[0]) ctrl_r[7:0]  <= writedata[7:0];
						if (byteenable[1]) ctrl_r[15:8] <= writedata[15:8];
					end
					`IDX_DELAYS_CH0: delays_r[0] <= writedata;
					`IDX_DELAYS_CH1: delays_r[1] <= writedata;
					`IDX_IRQ_MASK:   irq_mask_r  <= writedata[`IRQ_W-1:0];
					default: ; // read-only or unmapped, writes ignored
				endcase
			end
		end
	end
endmodule // delay_status_bank
`default_nettype wire

// [src/delay_status_regs.vh]
`ifndef DELAY_STATUS_REGS_VH
`define DELAY_STATUS_REGS_VH
// byte-image indices, byte address is four times the index
`define IDX_CH0_ERRORS      4'h0
`define IDX_CH0_CTRL_STS    4'h1
`define IDX_CH0_RUN_PINS    4'h2
`define IDX_CH0_EDGE_CNT    4'h3
`define IDX_CH1_ERRORS      4'h8
`define IDX_CH1_CTRL_STS    4'h9
`define IDX_CH1_RUN_PINS    4'ha
`define IDX_CH1_EDGE_CNT    4'hb
`define CH_STRIDE           4'h8
// own control/interrupt registers
`define IDX_CTRL            4'h4
`define IDX_DELAYS_CH0      4'h5
`define IDX_IRQ_STATUS      4'h6
`define IDX_IRQ_MASK        4'h7
`define IDX_DELAYS_CH1      4'hd
// field positions
`define BIT_SLOT_INVALID    7
`define BIT_LOAD_ACK        2
`define BIT_READY           4
`define BIT_SOFT_EN         5
`define BIT_RUNNING         0
`define BIT_OUT_A           1
`define BIT_OUT_B           2
`define BIT_IN0             3
// control register fields (per channel: ch*8 + field)
`define CTL_SOFT_EN         0
`define CTL_SLOT_PERM       1
`define CTL_LOAD_REQ        2
`define CTL_PARAM_DONE      3
`define CTL_OUT_B           4
// delays register: on delay low half, off delay high half
`define DELAY_W             16
`define DELAY_RESET         32'h0000_0000
// irq status bits
`define IRQ_EDGE0           0
`define IRQ_LOAD0           1
`define IRQ_EDGE1           2
`define IRQ_LOAD1           3
`define IRQ_W               4
`endif

// [src/delay_channel.v]
`timescale 1ns/1ns
`default_nettype none
// one on/off-delay channel with its status sources
module delay_channel #(
	parameter DELAY_W = 16
) (
	input  wire               clock,
	input  wire               rst,
	input  wire               in0_pin,
	input  wire               soft_enable_request,
	input  wire               slot_perm_mode,
	input  wire               slot_load_request,
	input  wire               param_done,
	input  wire               out_b_req,
	input  wire [DELAY_W-1:0] on_delay,
	input  wire [DELAY_W-1:0] off_delay,
	output reg                pulse_out_main,
	output reg                pulse_out_second,
	output reg                in0_level,
	output reg                sequence_running_flag,
	output reg                load_ack_toggle,
	output reg                param_ready_flag,
	output reg                slot_value_invalid,
	output reg  [3:0]         out_edge_count,
	output wire               edge_pulse,
	output wire               load_pulse
);
	reg               in_sync1_r;
	reg               in_sync2_r;
	reg [DELAY_W-1:0] timer_r;
	reg               busy_r;
	reg               target_r;
	reg               load_req_d_r;
	reg               main_d_r;

	// pin is asynchronous; second stage is the only reader of the first
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			in_sync1_r <= 1'b0;
			in_sync2_r <= 1'b0;
			in0_level  <= 1'b0;
		end else begin
			in_sync1_r <= in0_pin;
			in_sync2_r <= in_sync1_r;
			in0_level  <= in_sync2_r;
		end
	end

	// any change of the main output counts, forced-off drops included;
	// one cycle late, but a restart racing the expiry cannot fake an edge
	assign edge_pulse = pulse_out_main ^ main_d_r;
	assign load_pulse = slot_load_request & ~load_req_d_r & ~slot_perm_mode & param_done;

	// delay engine: a new input level restarts the timer, output follows on expiry
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			timer_r               <= {DELAY_W{1'b0}};
			busy_r                <= 1'b0;
			target_r              <= 1'b0;
			pulse_out_main        <= 1'b0;
			sequence_running_flag <= 1'b0;
		end else begin
			sequence_running_flag <= soft_enable_request & param_done;
			if (!(soft_enable_request & param_done)) begin
				busy_r         <= 1'b0;
				pulse_out_main <= 1'b0;
			end else if (in0_level != target_r || (!busy_r && in0_level != pulse_out_main)) begin
				target_r <= in0_level;
				busy_r   <= 1'b1;
				timer_r  <= in0_level ? on_delay : off_delay;
			end else if (busy_r) begin
				if (timer_r == {DELAY_W{1'b0}}) begin
					pulse_out_main <= target_r;
					busy_r         <= 1'b0;
				end else begin
					timer_r <= timer_r - {{(DELAY_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// status sources
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			load_req_d_r       <= 1'b0;
			main_d_r           <= 1'b0;
			load_ack_toggle    <= 1'b0;
			param_ready_flag   <= 1'b0;
			slot_value_invalid <= 1'b0;
			out_edge_count     <= 4'h0;
			pulse_out_second   <= 1'b0;
		end else begin
			load_req_d_r     <= slot_load_request;
			main_d_r         <= pulse_out_main;
			param_ready_flag <= param_done;
			pulse_out_second <= out_b_req & ~pulse_out_main;
			if (load_pulse)
				load_ack_toggle <= ~load_ack_toggle;
			// a zero on delay in permanent mode counts as an invalid slot value
			slot_value_invalid <= slot_perm_mode & (on_delay == {DELAY_W{1'b0}});
			if (edge_pulse)
				out_edge_count <= out_edge_count + 4'h1; // wraps 15 to 0
		end
	end
endmodule // delay_channel
`default_nettype wire

// [dv/in_pin_driver.sv]
`timescale 1ns/1ns
`default_nettype none
// field side of the digital inputs, one level per channel
module in_pin_driver (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [1:0] lvl,
	output var  logic [1:0] in0_pin
);
	// launched off the clock so the input synchroniser sees clean steps
	always @(posedge clock or posedge rst) begin
		if (rst)
			in0_pin <= 2'h0;
		else
			in0_pin <= lvl;
	end
endmodule // in_pin_driver
`default_nettype wire

// [dv/delay_status_props.sv]
`timescale 1ns/1ns
`default_nettype none
module delay_status_props (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [5:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [1:0]  pulse_out_main,
	input wire logic [1:0]  pulse_out_second,
	input wire logic        irq
);
	// read data only counts at the completing edge
	wire logic       done = read & ~waitrequest;
	wire logic [3:0] idx  = address[5:2];
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_wait_first: assert property ((read | write) & ~$past(read | write) |-> waitrequest)
		else $error("new request not held off");
	a_wait_ends: assert property ((read | write) |-> ##[0:2] ~waitrequest)
		else $error("request never answered");
	a_upper_zero: assert property (done & ~idx[2] |-> readdata[31:8] == 24'h0)
		else $error("status upper bits not zero");
	a_count_high: assert property (done & ~idx[2] & idx[1:0] == 2'h3 |-> readdata[7:4] == 4'h0)
		else $error("counter byte upper nibble not zero");
	a_main_level: assert property (done & idx == 4'h2 |-> readdata[1] == $past(pulse_out_main[0]))
		else $error("main output level misreported");
	a_second_level: assert property (done & idx == 4'h2 |-> readdata[2] == $past(pulse_out_second[0]))
		else $error("second output level misreported");
	a_ch1_main: assert property (done & idx == 4'ha |-> readdata[1] == $past(pulse_out_main[1]))
		else $error("channel 1 main level misreported");
	a_idle_low: assert property (done & idx == 4'h2 & ~readdata[0] |-> ~$past(pulse_out_main[0]))
		else $error("main output high while idle");
	c_main_high: cover property (done & idx == 4'h2 & readdata[1]);
	c_irq: cover property ($rose(irq));
	c_ch1: cover property (done & idx == 4'ha);
endmodule // delay_status_props
bind delay_status_bank delay_status_props i_props (.clock(clock), .rst(rst), .address(address),
	.read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
	.pulse_out_main(pulse_out_main), .pulse_out_second(pulse_out_second), .irq(irq));
`default_nettype wire

// [dv/delay_status_bank_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module delay_status_bank_bench;
	logic        clock = 0, rst = 1, read = 0, write = 0;
	logic [5:0]  address = 6'h0;
	logic [31:0] writedata = 32'h0, q;
	logic [3:0]  byteenable = 4'h0;
	logic [1:0]  lvl = 2'h0;
	wire  [31:0] readdata;
	wire         waitrequest, irq;
	wire  [1:0]  in0_pin, pulse_out_main, pulse_out_second;
	int          fail_count = 0, samples_checked = 0;
	always #20 clock = ~clock;
	in_pin_driver i_pins (.clock(clock), .rst(rst), .lvl(lvl), .in0_pin(in0_pin));
	delay_status_bank i_dut (.clock(clock), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .in0_pin(in0_pin), .pulse_out_main(pulse_out_main),
		.pulse_out_second(pulse_out_second), .irq(irq));
	task tally_and_finish;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access; request held until waitrequest is seen low at a rising edge,
	// an idle edge first so a release is never followed by a raise in one step
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= d;
		byteenable <= 4'hf;
		read <= ~wr;
		write <= wr;
		@(posedge clock);
		while (waitrequest !== 1'b0 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n == 20)
			fail_count++;
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task rd(input logic [3:0] i, input logic [7:0] e);
		bus(1'b0, {i, 2'b00}, 32'h0);
		chk(q, {24'h0, e});
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clock);
	endtask
	task t_reset;
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'h3, 8'h00);
		rd(4'he, 8'h00);
		rd(4'h9, 8'h00);
	endtask
	task t_enable;
		bus(1'b1, 6'h10, 32'h9);
		rd(4'h1, 8'h30);
		rd(4'h2, 8'h01);
	endtask
	task t_delay;
		bus(1'b1, 6'h14, 32'h000a_000a);
		lvl <= 2'h1;
		wait_n(6);
		chk(pulse_out_main[0], 1'b0);
		wait_n(40);
		chk(pulse_out_main[0], 1'b1);
		rd(4'h2, 8'h0b);
		lvl <= 2'h0;
		wait_n(6);
		chk(pulse_out_main[0], 1'b1);
		wait_n(40);
		chk(pulse_out_main[0], 1'b0);
		rd(4'h3, 8'h02);
	endtask
	// sixteen more edges bring the count back round
	task t_wrap;
		repeat (8) begin
			lvl <= 2'h1;
			wait_n(40);
			lvl <= 2'h0;
			wait_n(40);
		end
		rd(4'h3, 8'h02);
	endtask
	task t_load_irq;
		chk(irq, 1'b0);
		bus(1'b1, 6'h1c, 32'h2);
		bus(1'b1, 6'h10, 32'hd);
		bus(1'b1, 6'h10, 32'h9);
		rd(4'h1, 8'h34);
		chk(irq, 1'b1);
		rd(4'h6, 8'h03);
		wait_n(1);
		chk(irq, 1'b0);
	endtask
	task t_slot;
		bus(1'b1, 6'h14, 32'h0);
		bus(1'b1, 6'h10, 32'hb);
		rd(4'h0, 8'h80);
		bus(1'b1, 6'h14, 32'h000a_000a);
		rd(4'h0, 8'h00);
	endtask
	task t_ch1;
		bus(1'b1, 6'h10, 32'h0910);
		rd(4'h2, 8'h04);
		rd(4'h9, 8'h30);
		lvl <= 2'h2;
		wait_n(12);
		rd(4'ha, 8'h0b);
		chk(pulse_out_main[1], 1'b1);
		chk(pulse_out_second[0], 1'b1);
	endtask
	initial begin
		#(40 * 20000);
		fail_count++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_enable;
		t_delay;
		t_wrap;
		t_load_irq;
		t_slot;
		t_ch1;
		tally_and_finish;
	end
endmodule // delay_status_bank_bench
`default_nettype wire
